/* hw/acms_params.svh */
// register map, field positions, mode codes and reset values
`ifndef ACMS_PARAMS_SVH
`define ACMS_PARAMS_SVH

`define ACMS_ADDR_W          4
`define ACMS_DATA_W          32
`define ACMS_WORD_W          24

`define ACMS_OFS_CTRL        4'h0
`define ACMS_OFS_DATA        4'h1
`define ACMS_OFS_STATUS      4'h2
`define ACMS_OFS_MASK        4'h3
`define ACMS_OFS_ZCOEF       4'h4
`define ACMS_OFS_FCOEF       4'h5

`define ACMS_MODE_LSB        0
`define ACMS_MODE_MSB        2
`define ACMS_CHAN_LSB        4
`define ACMS_CHAN_MSB        6
`define ACMS_GAIN_LSB        8
`define ACMS_GAIN_MSB        10
`define ACMS_FLAG_BIT        8

`define ACMS_MODE_NORMAL     3'h0
`define ACMS_MODE_BACKGND    3'h5
`define ACMS_MODE_ZEROCAL    3'h6
`define ACMS_MODE_FULLCAL    3'h7

`define ACMS_EVT_W           3
`define ACMS_EVT_WORD        0
`define ACMS_EVT_CALDONE     1
`define ACMS_EVT_BGREFRESH   2

`define ACMS_BG_RATIO        6
`define ACMS_ZCOEF_RST       24'h00_0000
`define ACMS_FCOEF_RST       24'h80_0000
`define ACMS_ZERO32          32'h0000_0000

`endif

/* hw/acms_pkg.sv */
// types shared by the calibration mode sequencer
package acms_pkg;
    typedef enum logic [1:0] {
        ACMS_KIND_CONV,
        ACMS_KIND_ZERO,
        ACMS_KIND_FULL
    } acms_kind_t;

    typedef enum logic [1:0] {
        ACMS_ST_ISSUE,
        ACMS_ST_CONV,
        ACMS_ST_CAL
    } acms_state_t;
endpackage : acms_pkg

/* hw/acms_bg_slot.sv */
// background-calibration slot counter: one conversion then SLOTS-1 cals
`timescale 1ns/10ps
`include "acms_params.svh"
module acms_bg_slot #(
    parameter int SLOTS = `ACMS_BG_RATIO
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // control
    input  wire logic active,
    input  wire logic cycleDone,
    // result
    output logic      calTurn
);
    localparam int CW = $clog2(SLOTS);

    initial
    begin
        if (SLOTS < 2)
            $error("acms_bg_slot: SLOTS must be at least 2");
    end

    logic [CW-1:0] slot_q;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            slot_q <= '0;
        else if (!active)
            slot_q <= '0;
        else if (cycleDone)
            slot_q <= (slot_q == CW'(SLOTS - 1)) ? '0 : slot_q + 1'b1;
    end

    assign calTurn = (slot_q != '0);
endmodule : acms_bg_slot

/* hw/acms_sequencer.sv */
// calibration mode sequencer with register port and interrupt
//
// Operation
// - Code 101 runs background calibration on selected channel until changed.
// - Background mode runs five cals per conversion so word rate drops to one sixth.
// - Background mode interleaves cals and refreshes the zero coefficient without host.
// - Background cals are zero-scale on shorted inputs; never full-scale.
// - Code 110 runs one zero-scale self-cal, selected channel and gain.
// - For 110 ready flag rises at start, falls after cal and new word.
// - Code 111 runs one full-scale self-cal against reference over gain.
// - For 111 ready flag rises at start, falls after cal and new word.
// - After 110 or 111 completes, mode clears to 000 and conversions resume.
// - Code 000 is normal conversion and the reset value.
`timescale 1ns/10ps
`include "acms_params.svh"
module acms_sequencer #(
    parameter int ADDR_W = `ACMS_ADDR_W,
    parameter int WORD_W = `ACMS_WORD_W
) (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst,
    // register port
    input  wire logic [ADDR_W-1:0]         regAddr,
    input  wire logic [`ACMS_DATA_W-1:0]   regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic      [`ACMS_DATA_W-1:0]   regRdata,
    // conversion engine
    output logic                           convStart,
    output acms_pkg::acms_kind_t           convKind,
    output logic      [2:0]                convChannel,
    output logic      [2:0]                convGain,
    input  wire logic                      convDone,
    input  wire logic [WORD_W-1:0]         convResult,
    // calibration coefficients to the engine
    output logic      [WORD_W-1:0]         zeroCoef,
    output logic      [WORD_W-1:0]         fullCoef,
    // status
    output logic                           conversionReadyFlag,
    output logic                           irq
);
    initial
    begin
        if (ADDR_W < 3 || WORD_W < 1 || WORD_W > `ACMS_DATA_W)
            $error("acms_sequencer: unsupported width");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [3:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction : hit

    logic [2:0]                  modeCode_q;
    logic [2:0]                  channel_q;
    logic [2:0]                  gain_q;
    logic [WORD_W-1:0]           dataWord_q;
    logic [`ACMS_EVT_W-1:0]      status_q;
    logic [`ACMS_EVT_W-1:0]      mask_q;
    logic [WORD_W-1:0]           zeroCoef_q;
    logic [WORD_W-1:0]           fullCoef_q;
    logic                        flag_q;
    logic                        irq_q;
    logic [`ACMS_DATA_W-1:0]     rdata_q;
    logic                        start_q;
    acms_pkg::acms_kind_t        kind_q;
    logic [2:0]                  convChan_q;
    logic [2:0]                  convGain_q;
    acms_pkg::acms_state_t       state_q;

    logic ctrlWr;
    logic inBg;
    logic calTurn;
    logic wordLoad;
    logic calFinish;
    logic oneStepDone;
    logic issueNow;
    acms_pkg::acms_kind_t nextKind;

    assign ctrlWr    = regWr && hit(regAddr, `ACMS_OFS_CTRL);
    assign inBg      = (modeCode_q == `ACMS_MODE_BACKGND);
    assign wordLoad  = convDone && (state_q == acms_pkg::ACMS_ST_CONV);
    assign calFinish = convDone && (state_q == acms_pkg::ACMS_ST_CAL);
    assign oneStepDone = calFinish && !inBg;
    assign issueNow    = (state_q == acms_pkg::ACMS_ST_ISSUE);

    acms_bg_slot #(
        .SLOTS     (`ACMS_BG_RATIO)
    ) u_slot (
        .mclk      (mclk),
        .rst       (rst),
        .active    (inBg),
        // count issues, not dones: the cycle running at entry is not counted
        .cycleDone (issueNow),
        .calTurn   (calTurn)
    );

    // the mode decides the next cycle; unsupported codes just convert
    always_comb
    begin
        unique case (modeCode_q)
            `ACMS_MODE_ZEROCAL: nextKind = acms_pkg::ACMS_KIND_ZERO;
            `ACMS_MODE_FULLCAL: nextKind = acms_pkg::ACMS_KIND_FULL;
            `ACMS_MODE_BACKGND: nextKind = calTurn ?
                acms_pkg::ACMS_KIND_ZERO : acms_pkg::ACMS_KIND_CONV;
            default:            nextKind = acms_pkg::ACMS_KIND_CONV;
        endcase
    end

    // control register; a host write beats the self-clear in the same cycle
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            modeCode_q <= `ACMS_MODE_NORMAL;
            channel_q  <= 3'h0;
            gain_q     <= 3'h0;
        end
        else if (ctrlWr)
        begin
            modeCode_q <= regWdata[`ACMS_MODE_MSB:`ACMS_MODE_LSB];
            channel_q  <= regWdata[`ACMS_CHAN_MSB:`ACMS_CHAN_LSB];
            gain_q     <= regWdata[`ACMS_GAIN_MSB:`ACMS_GAIN_LSB];
        end
        else if (oneStepDone)
            modeCode_q <= `ACMS_MODE_NORMAL;
        // background code is left alone here: and
    end

    // cycle scheduler: one outstanding engine cycle at a time
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_q    <= acms_pkg::ACMS_ST_ISSUE;
            start_q    <= 1'b0;
            kind_q     <= acms_pkg::ACMS_KIND_CONV;
            convChan_q <= 3'h0;
            convGain_q <= 3'h0;
        end
        else
        begin
            start_q <= 1'b0;
            unique case (state_q)
                acms_pkg::ACMS_ST_ISSUE:
                begin
                    start_q    <= 1'b1;
                    kind_q     <= nextKind;
                    convChan_q <= channel_q;
                    convGain_q <= gain_q;
                    state_q    <= (nextKind == acms_pkg::ACMS_KIND_CONV) ?
                                  acms_pkg::ACMS_ST_CONV :
                                  acms_pkg::ACMS_ST_CAL;
                end
                acms_pkg::ACMS_ST_CONV,
                acms_pkg::ACMS_ST_CAL:
                    if (convDone)
                        state_q <= acms_pkg::ACMS_ST_ISSUE;
            endcase
        end
    end

    // coefficients: host may load them, finished cals overwrite them
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            zeroCoef_q <= `ACMS_ZCOEF_RST;
            fullCoef_q <= `ACMS_FCOEF_RST;
        end
        else
        begin
            if (calFinish && kind_q == acms_pkg::ACMS_KIND_ZERO)
                zeroCoef_q <= convResult;
            else if (regWr && hit(regAddr, `ACMS_OFS_ZCOEF))
                zeroCoef_q <= regWdata[WORD_W-1:0];
            if (calFinish && kind_q == acms_pkg::ACMS_KIND_FULL)
                fullCoef_q <= convResult;
            else if (regWr && hit(regAddr, `ACMS_OFS_FCOEF))
                fullCoef_q <= regWdata[WORD_W-1:0];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            dataWord_q <= '0;
        else if (wordLoad)
            dataWord_q <= convResult;
    end

    // ready flag is high while no fresh word waits; a load wins over all
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            flag_q <= 1'b1;
        else if (wordLoad)
            flag_q <= 1'b0;
        else if (state_q == acms_pkg::ACMS_ST_ISSUE &&
                 nextKind != acms_pkg::ACMS_KIND_CONV && !inBg)
            flag_q <= 1'b1;
        else if (regRd && hit(regAddr, `ACMS_OFS_DATA))
            flag_q <= 1'b1;
    end

    // sticky events, write one to clear; a new event wins over the clear
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            status_q <= '0;
            mask_q   <= '0;
        end
        else
        begin
            for (int i = 0; i < `ACMS_EVT_W; i++)
            begin
                if (regWr && hit(regAddr, `ACMS_OFS_STATUS) && regWdata[i])
                    status_q[i] <= 1'b0;
            end
            if (wordLoad)
                status_q[`ACMS_EVT_WORD] <= 1'b1;
            if (oneStepDone)
                status_q[`ACMS_EVT_CALDONE] <= 1'b1;
            if (calFinish && inBg)
                status_q[`ACMS_EVT_BGREFRESH] <= 1'b1;
            if (regWr && hit(regAddr, `ACMS_OFS_MASK))
                mask_q <= regWdata[`ACMS_EVT_W-1:0];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            irq_q <= 1'b0;
        else
            irq_q <= |(status_q & mask_q);
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rdata_q <= `ACMS_ZERO32;
        else
        begin
            rdata_q <= `ACMS_ZERO32;
            if (regRd)
            begin
                if (hit(regAddr, `ACMS_OFS_CTRL))
                begin
                    rdata_q[`ACMS_MODE_MSB:`ACMS_MODE_LSB] <= modeCode_q;
                    rdata_q[`ACMS_CHAN_MSB:`ACMS_CHAN_LSB] <= channel_q;
                    rdata_q[`ACMS_GAIN_MSB:`ACMS_GAIN_LSB] <= gain_q;
                end
                else if (hit(regAddr, `ACMS_OFS_DATA))
                    rdata_q[WORD_W-1:0] <= dataWord_q;
                else if (hit(regAddr, `ACMS_OFS_STATUS))
                begin
                    rdata_q[`ACMS_EVT_W-1:0] <= status_q;
                    rdata_q[`ACMS_FLAG_BIT]  <= flag_q;
                end
                else if (hit(regAddr, `ACMS_OFS_MASK))
                    rdata_q[`ACMS_EVT_W-1:0] <= mask_q;
                else if (hit(regAddr, `ACMS_OFS_ZCOEF))
                    rdata_q[WORD_W-1:0] <= zeroCoef_q;
                else if (hit(regAddr, `ACMS_OFS_FCOEF))
                    rdata_q[WORD_W-1:0] <= fullCoef_q;
            end
        end
    end

    assign regRdata            = rdata_q;
    assign convStart           = start_q;
    assign convKind            = kind_q;
    assign convChannel         = convChan_q;
    assign convGain            = convGain_q;
    assign zeroCoef            = zeroCoef_q;
    assign fullCoef            = fullCoef_q;
    assign conversionReadyFlag = flag_q;
    assign irq                 = irq_q;

    // helper: cal starts since the last conversion start in background mode
    logic [3:0] bgCals_q;
    logic       bgRun_q;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            bgCals_q <= 4'h0;
            bgRun_q  <= 1'b0;
        end
        else if (!inBg)
        begin
            bgCals_q <= 4'h0;
            bgRun_q  <= 1'b0;
        end
        else if (start_q && kind_q == acms_pkg::ACMS_KIND_CONV)
        begin
            bgCals_q <= 4'h0;
            bgRun_q  <= 1'b1;
        end
        else if (start_q)
            bgCals_q <= bgCals_q + 4'h1;
    end

    localparam logic [3:0] BG_CALS = 4'(`ACMS_BG_RATIO - 1);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_calDone;
        calFinish && !inBg && !ctrlWr;
    endsequence

    sequence s_wordLoad;
        convDone && state_q == acms_pkg::ACMS_ST_CONV;
    endsequence

    property p_resetMode;
        $fell(rst) |-> modeCode_q == `ACMS_MODE_NORMAL;
    endproperty
    a_resetMode: assert property (p_resetMode)
        else $error("mode not normal after reset");

    property p_bgHolds;
        inBg && !ctrlWr |=> inBg;
    endproperty
    a_bgHolds: assert property (p_bgHolds)
        else $error("background mode left without a host write");

    property p_selfClear;
        s_calDone |=> modeCode_q == `ACMS_MODE_NORMAL;
    endproperty
    a_selfClear: assert property (p_selfClear)
        else $error("one-step cal did not clear the mode");

    property p_flagAtCal;
        start_q && kind_q != acms_pkg::ACMS_KIND_CONV && !$past(inBg)
            |-> flag_q;
    endproperty
    a_flagAtCal: assert property (p_flagAtCal)
        else $error("ready flag not high at cal start");

    property p_flagFall;
        $fell(flag_q) |-> $past(wordLoad);
    endproperty
    a_flagFall: assert property (p_flagFall)
        else $error("ready flag fell without a new word");

    property p_calThenWord;
        s_calDone ##1 (state_q == acms_pkg::ACMS_ST_ISSUE && !ctrlWr)
            |=> start_q && kind_q == acms_pkg::ACMS_KIND_CONV;
    endproperty
    a_calThenWord: assert property (p_calThenWord)
        else $error("no conversion after one-step cal");

    property p_bgNoFull;
        start_q && $past(inBg) |-> kind_q != acms_pkg::ACMS_KIND_FULL;
    endproperty
    a_bgNoFull: assert property (p_bgNoFull)
        else $error("full-scale cal in background mode");

    property p_bgRatio;
        start_q && kind_q == acms_pkg::ACMS_KIND_CONV && inBg && bgRun_q
            |-> bgCals_q == BG_CALS;
    endproperty
    a_bgRatio: assert property (p_bgRatio)
        else $error("background cal count per word wrong");

    property p_bgRefresh;
        calFinish && inBg && kind_q == acms_pkg::ACMS_KIND_ZERO
            |=> zeroCoef_q == $past(convResult);
    endproperty
    a_bgRefresh: assert property (p_bgRefresh)
        else $error("zero coefficient not refreshed");

    property p_chanFollow;
        start_q |-> convChan_q == $past(channel_q);
    endproperty
    a_chanFollow: assert property (p_chanFollow)
        else $error("cycle not on selected channel");

    property p_loadData;
        s_wordLoad |=> dataWord_q == $past(convResult) && !flag_q;
    endproperty
    a_loadData: assert property (p_loadData)
        else $error("data word not loaded");
endmodule : acms_sequencer

/* verification/acms_engine_model.sv */
// behavioural conversion engine answering every start with one done pulse
`timescale 1ns/10ps
module acms_engine_model (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // start side
    input  wire logic                 convStart,
    input  wire acms_pkg::acms_kind_t convKind,
    input  wire logic [2:0]           convChannel,
    input  wire logic [2:0]           convGain,
    input  wire logic [7:0]           latency,
    // answer side
    output logic                      convDone,
    output logic [23:0]               convResult
);
    logic        busy_q;
    logic [7:0]  cnt_q;
    logic [11:0] seq_q;
    logic [23:0] res_q;

    // result carries kind, channel and gain so the bench can trace them
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            busy_q   <= 1'b0;
            cnt_q    <= 8'h00;
            seq_q    <= 12'h000;
            res_q    <= 24'h00_0000;
            convDone <= 1'b0;
        end
        else
        begin
            convDone <= 1'b0;
            if (convStart)
            begin
                busy_q <= 1'b1;
                cnt_q  <= latency;
            end
            else if (busy_q && cnt_q == 8'h00)
            begin
                busy_q   <= 1'b0;
                convDone <= 1'b1;
                seq_q    <= seq_q + 12'h001;
                res_q    <= {4'h0, convKind, convChannel, convGain, seq_q};
            end
            else if (busy_q)
                cnt_q <= cnt_q - 8'h01;
        end
    end

    // outside the done cycle the word is not held: show its inverse
    assign convResult = convDone ? res_q : ~res_q;
endmodule : acms_engine_model

/* verification/tb_top.sv */
// self-checking bench for the calibration mode sequencer
`timescale 1ns/10ps
`include "acms_params.svh"
module tb_top;
    typedef struct {
        logic        wr;
        logic [3:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } acms_row_t;

    logic                 mclk;
    logic                 rst;
    logic [3:0]           regAddr;
    logic [31:0]          regWdata;
    logic                 regWr;
    logic                 regRd;
    logic [31:0]          regRdata;
    logic                 convStart;
    acms_pkg::acms_kind_t convKind;
    logic [2:0]           convChannel;
    logic [2:0]           convGain;
    logic                 convDone;
    logic [23:0]          convResult;
    logic [23:0]          zeroCoef;
    logic [23:0]          fullCoef;
    logic                 conversionReadyFlag;
    logic                 irq;
    logic [7:0]           engLat;
    logic [31:0]          rdV;
    logic [23:0]          lastRes;
    int                   failCount = 0;
    int                   nChecks = 0;

    acms_row_t rows [10] = '{
        '{1'b1, `ACMS_OFS_MASK, 32'h0000_00FF, 32'h0000_0000},
        '{1'b0, `ACMS_OFS_MASK, 32'h0000_0000, 32'h0000_0007},
        '{1'b1, `ACMS_OFS_ZCOEF, 32'hFF12_3456, 32'h0000_0000},
        '{1'b0, `ACMS_OFS_ZCOEF, 32'h0000_0000, 32'h0012_3456},
        '{1'b1, 4'hF, 32'h0000_0001, 32'h0000_0000},
        '{1'b0, 4'hF, 32'h0000_0000, 32'h0000_0000},
        '{1'b1, `ACMS_OFS_MASK, 32'h0000_0002, 32'h0000_0000},
        '{1'b0, `ACMS_OFS_MASK, 32'h0000_0000, 32'h0000_0002},
        '{1'b1, `ACMS_OFS_CTRL, 32'h0000_0001, 32'h0000_0000},
        '{1'b0, `ACMS_OFS_CTRL, 32'h0000_0000, 32'h0000_0001}
    };

    acms_sequencer dut_u (
        .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .convStart(convStart), .convKind(convKind),
        .convChannel(convChannel), .convGain(convGain),
        .convDone(convDone), .convResult(convResult),
        .zeroCoef(zeroCoef), .fullCoef(fullCoef),
        .conversionReadyFlag(conversionReadyFlag), .irq(irq)
    );

    acms_engine_model eng_u (
        .mclk(mclk), .rst(rst), .convStart(convStart),
        .convKind(convKind), .convChannel(convChannel),
        .convGain(convGain), .latency(engLat),
        .convDone(convDone), .convResult(convResult)
    );

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic test_done();
        if (failCount == 0 && nChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge mclk);
        regWr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd   <= 1'b0;
        #1;
        rdV = regRdata;
    endtask : rd

    // bounded wait for a start (0) or a done (1) of the engine link
    task automatic wait_for(input bit forDone);
        for (int i = 0; i < 2000; i++)
        begin
            @(posedge mclk);
            #1;
            if (forDone ? convDone === 1'b1 : convStart === 1'b1)
            begin
                if (forDone)
                    lastRes = convResult;
                return;
            end
        end
        failCount++;
        test_done();
    endtask : wait_for

    // one-step cal on channel 3, gain 5; mask enables the cal-done event
    task automatic one_step(input logic [2:0] code,
                            input acms_pkg::acms_kind_t kind);
        wait_for(0);
        wr(`ACMS_OFS_CTRL, {29'h0000_0530 >> 3, code});
        wait_for(0);
        check("calKind", convKind, kind);
        check("calChan", convChannel, 32'h0000_0003);
        check("calGain", convGain, 32'h0000_0005);
        check("calFlag", conversionReadyFlag, 32'h0000_0001);
        wait_for(1);
        // the next start follows two edges after the done: catch it first
        wait_for(0);
        check("resume", convKind, acms_pkg::ACMS_KIND_CONV);
        check("flagHeld", conversionReadyFlag, 32'h0000_0001);
        rd(`ACMS_OFS_CTRL);
        check("ctrlAfter", rdV, 32'h0000_0530);
        check("coef", code[0] ? fullCoef : zeroCoef, lastRes);
        check("irqSet", irq, 32'h0000_0001);
        wr(`ACMS_OFS_STATUS, 32'h0000_0002);
        @(posedge mclk);
        #1;
        check("irqClr", irq, 32'h0000_0000);
        wait_for(1);
        @(posedge mclk);
        #1;
        check("flagLow", conversionReadyFlag, 32'h0000_0000);
    endtask : one_step

    initial
    begin
        rst      = 1'b1;
        regAddr  = 4'h0;
        regWdata = 32'h0000_0000;
        regWr    = 1'b0;
        regRd    = 1'b0;
        engLat   = 8'h14;
        repeat (2) @(posedge mclk);
        #1;
        check("rstFlag", conversionReadyFlag, 32'h0000_0001);
        check("rstIrq", irq, 32'h0000_0000);
        check("rstZero", zeroCoef, `ACMS_ZCOEF_RST);
        check("rstFull", fullCoef, `ACMS_FCOEF_RST);
        @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        check("firstStart", convStart, 32'h0000_0001);
        rd(`ACMS_OFS_CTRL);
        check("rstMode", rdV, 32'h0000_0000);
        wait_for(1);
        @(posedge mclk);
        #1;
        check("wordFlag", conversionReadyFlag, 32'h0000_0000);
        rd(`ACMS_OFS_DATA);
        check("dataWord", rdV, {8'h00, lastRes});
        check("readFlag", conversionReadyFlag, 32'h0000_0001);
        foreach (rows[i])
        begin
            if (rows[i].wr)
                wr(rows[i].a, rows[i].d);
            else
            begin
                rd(rows[i].a);
                check("row", rdV, rows[i].e);
            end
        end
        check("irqMasked", irq, 32'h0000_0000);
        one_step(3'h6, acms_pkg::ACMS_KIND_ZERO);
        one_step(3'h7, acms_pkg::ACMS_KIND_FULL);
        // background: fast engine keeps the run short
        wait_for(0);
        engLat <= 8'h01;
        wr(`ACMS_OFS_CTRL, 32'h0000_0535);
        for (int i = 0; i < 12; i++)
        begin
            wait_for(0);
            check("bgKind", convKind, (i % 6 == 0) ? acms_pkg::ACMS_KIND_CONV
                  : acms_pkg::ACMS_KIND_ZERO);
            check("bgChan", convChannel, 32'h0000_0003);
        end
        wait_for(1);
        @(posedge mclk);
        #1;
        check("bgCoef", zeroCoef, lastRes);
        rd(`ACMS_OFS_CTRL);
        check("bgMode", rdV, 32'h0000_0535);
        rd(`ACMS_OFS_STATUS);
        check("bgEvt", rdV & 32'h0000_0004, 32'h0000_0004);
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        rd(`ACMS_OFS_CTRL);
        check("reRst", rdV, 32'h0000_0000);
        test_done();
    end
endmodule : tb_top
